// >>> include/tvs_cfg.svh
// Timing and limits of the temperature/voltage sensor sequencer.
// Assumes a single 200 MHz system clock; times are in ns.
`ifndef TVS_CFG_SVH
`define TVS_CFG_SVH

// ==========================================================
// Clock
`define TVS_CLK_NS          5

// ==========================================================
// Times as specified
`define TVS_FIRST_MIN_NS    420000
`define TVS_FIRST_MAX_NS    470000
`define TVS_SPACE_NS        480000
`define TVS_VALID_MIN_NS    1625
`define TVS_VALID_MAX_NS    2000
`define TVS_CAL_MAX_NS      375
`define TVS_SAMPLE_LEAD_NS  25
`define TVS_RATE_UNIT_NS    32000

// ==========================================================
// Cycle counts (least times round up, longest round down)
`define TVS_FIRST_MIN_CYC   \
	((`TVS_FIRST_MIN_NS + `TVS_CLK_NS - 1) / `TVS_CLK_NS)
`define TVS_FIRST_MAX_CYC   (`TVS_FIRST_MAX_NS / `TVS_CLK_NS)
`define TVS_SPACE_CYC       (`TVS_SPACE_NS / `TVS_CLK_NS)
`define TVS_VALID_MIN_CYC   \
	((`TVS_VALID_MIN_NS + `TVS_CLK_NS - 1) / `TVS_CLK_NS)
`define TVS_VALID_MAX_CYC   (`TVS_VALID_MAX_NS / `TVS_CLK_NS)
`define TVS_CAL_MAX_CYC     (`TVS_CAL_MAX_NS / `TVS_CLK_NS)
`define TVS_SAMPLE_CYC      \
	((`TVS_SAMPLE_LEAD_NS + `TVS_CLK_NS - 1) / `TVS_CLK_NS)
`define TVS_RATE_UNIT_CYC   (`TVS_RATE_UNIT_NS / `TVS_CLK_NS)

// ==========================================================
// Widths
`define TVS_TMR_W           24
`define TVS_VLD_W           9
`define TVS_CAL_W           6

`endif

// >>> include/tvs_pkg.sv
// Types shared by the sensor sequencer modules.
// Assumes tvs_cfg.svh is compiled alongside.
package tvs_pkg;

	// ==========================================================
	// Sequencer states
	typedef enum logic [3:0] {
		TVS_ST_IDLE  = 4'h1,
		TVS_ST_CONV  = 4'h2,
		TVS_ST_VALID = 4'h4,
		TVS_ST_WAIT  = 4'h8
	} tvs_state_t;

	// ==========================================================
	// Raw sensor word and presented result
	typedef logic [15:0] tvs_sample_t;

	typedef struct packed {
		logic [1:0]  chan;
		tvs_sample_t data;
	} tvs_result_t;

endpackage

// >>> src/tvs_timer.sv
// Loadable down counter that parks at zero.
// Assumes one clock domain with an asynchronous active-high reset.
`timescale 1ns/1ps
module tvs_timer #(
	parameter int W = 24
) (
	// Clock and reset
	input  wire logic         clk_sys,
	input  wire logic         sys_rst,
	// Control
	input  wire logic         load,
	input  wire logic [W-1:0] load_val,
	// Status
	output logic      [W-1:0] count,
	output logic              zero
);
	logic [W-1:0] cnt_q;
	logic [W-1:0] cnt_d;

	always_comb begin
		cnt_d = cnt_q;
		if (load) begin
			cnt_d = load_val;
		end else if (cnt_q != '0) begin
			cnt_d = cnt_q - W'(1);
		end
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			cnt_q <= '0;
		end else begin
			cnt_q <= cnt_d;
		end
	end

	assign count = cnt_q;
	assign zero  = (cnt_q == '0);
endmodule

// >>> src/tvs_next_chan.sv
// Finds the lowest enabled channel at or above a start index.
// Purely combinational; start index 4 means none left.
`timescale 1ns/1ps
module tvs_next_chan (
	// Query
	input  wire logic [3:0] chan_en,
	input  wire logic [2:0] from_chan,
	// Answer
	output logic            found,
	output logic      [1:0] chan
);
	always_comb begin
		found = 1'b0;
		chan  = 2'h0;
		for (int i = 3; i >= 0; i--) begin
			if (chan_en[i] && (3'(i) >= from_chan)) begin
				found = 1'b1;
				chan  = 2'(i);
			end
		end
	end
endmodule

// >>> src/tvs_seq.sv
// Round-robin sequencer for the temperature and voltage sensor unit.
// Assumes enables, power-down and rate come from logic on clk_sys and
// that the raw sample is stable whenever a conversion completes.
`timescale 1ns/1ps
`include "tvs_cfg.svh"

module tvs_seq #(
	parameter int FIRST_MIN_CYC = `TVS_FIRST_MIN_CYC,
	parameter int FIRST_MAX_CYC = `TVS_FIRST_MAX_CYC,
	parameter int SPACE_CYC     = `TVS_SPACE_CYC,
	parameter int RATE_UNIT_CYC = `TVS_RATE_UNIT_CYC
) (
	// Clock and reset
	input  wire logic                clk_sys,
	input  wire logic                sys_rst,
	// User control
	input  wire logic [3:0]          chan_enable,
	input  wire logic                sensor_power_down,
	input  wire logic [7:0]          rate_param,
	// Sensor raw value
	input  wire tvs_pkg::tvs_sample_t raw_sample,
	// Result
	output tvs_pkg::tvs_result_t     result,
	output logic                     result_valid
);
	import tvs_pkg::*;

	// ==========================================================
	// State
	tvs_state_t                state_q,  state_d;
	tvs_result_t               result_q, result_d;
	logic [3:0]                en_prev_q;
	logic [3:0]                en_smp_q, en_smp_d;
	logic [`TVS_CAL_W-1:0]     extra_q,  extra_d;
	logic [1:0]                cur_q,    cur_d;

	logic                      conv_load, rate_load, vld_load;
	logic [`TVS_TMR_W-1:0]     conv_val,  rate_val;
	logic [`TVS_VLD_W-1:0]     vld_val,   vld_cnt;
	logic                      conv_zero, rate_zero, vld_zero;
	logic                      round_start, conv_done;
	logic [3:0]                lo_en;
	logic                      lo_found, nx_found;
	logic [1:0]                lo_chan,  nx_chan;

	// ==========================================================
	// Timers and channel pickers
	tvs_timer #(.W(`TVS_TMR_W)) u_conv_tmr (
		.clk_sys  (clk_sys),
		.sys_rst  (sys_rst),
		.load     (conv_load),
		.load_val (conv_val),
		.count    (),
		.zero     (conv_zero)
	);

	tvs_timer #(.W(`TVS_TMR_W)) u_rate_tmr (
		.clk_sys  (clk_sys),
		.sys_rst  (sys_rst),
		.load     (rate_load),
		.load_val (rate_val),
		.count    (),
		.zero     (rate_zero)
	);

	tvs_timer #(.W(`TVS_VLD_W)) u_vld_tmr (
		.clk_sys  (clk_sys),
		.sys_rst  (sys_rst),
		.load     (vld_load),
		.load_val (vld_val),
		.count    (vld_cnt),
		.zero     (vld_zero)
	);

	assign lo_en = (state_q == TVS_ST_IDLE) ? chan_enable : en_smp_q;

	tvs_next_chan u_pick_lo (
		.chan_en   (lo_en),
		.from_chan (3'h0),
		.found     (lo_found),
		.chan      (lo_chan)
	);

	tvs_next_chan u_pick_nx (
		.chan_en   (en_smp_q),
		.from_chan (3'({1'b0, cur_q}) + 3'h1),
		.found     (nx_found),
		.chan      (nx_chan)
	);

	// ==========================================================
	// Sequencer next state
	always_comb begin
		state_d     = state_q;
		result_d    = result_q;
		en_smp_d    = en_smp_q;
		extra_d     = extra_q;
		cur_d       = cur_q;
		conv_load   = 1'b0;
		conv_val    = '0;
		rate_load   = 1'b0;
		rate_val    = 24'(int'(rate_param) * RATE_UNIT_CYC - 1);
		vld_load    = 1'b0;
		vld_val     = '0;
		round_start = 1'b0;
		conv_done   = 1'b0;
		unique case (state_q)
			TVS_ST_IDLE: begin
				if (en_prev_q == 4'h0 && chan_enable != 4'h0) begin
					conv_load     = 1'b1;
					conv_val      = sensor_power_down ?
						24'(FIRST_MAX_CYC - 1) :
						24'(FIRST_MIN_CYC - 1);
					rate_load     = 1'b1;
					round_start   = 1'b1;
					cur_d         = lo_chan;
					state_d       = TVS_ST_CONV;
				end
			end
			TVS_ST_CONV: begin
				if (conv_zero) begin
					conv_done     = 1'b1;
					result_d.chan = cur_q;
					result_d.data = raw_sample;
					extra_d       = raw_sample[`TVS_CAL_W-1:0];
					vld_load      = 1'b1;
					vld_val       = 9'(`TVS_VALID_MIN_CYC - 1 +
						int'(raw_sample[`TVS_CAL_W-1:0]));
					conv_load     = 1'b1;
					conv_val      = 24'(SPACE_CYC - 1);
					state_d       = TVS_ST_VALID;
				end
			end
			TVS_ST_VALID: begin
				if (vld_cnt == 9'(`TVS_SAMPLE_CYC - 1)) begin
					en_smp_d = chan_enable;
				end
				if (vld_zero) begin
					if (en_smp_q == 4'h0) begin
						state_d = TVS_ST_IDLE;
					end else if (nx_found) begin
						cur_d         = nx_chan;
						state_d       = TVS_ST_CONV;
					end else begin
						state_d = TVS_ST_WAIT;
					end
				end
			end
			TVS_ST_WAIT: begin
				if (rate_zero) begin
					conv_load     = 1'b1;
					conv_val      = 24'(SPACE_CYC - 1);
					rate_load     = 1'b1;
					round_start   = 1'b1;
					cur_d         = lo_chan;
					state_d       = TVS_ST_CONV;
				end
			end
			default: begin
				state_d = TVS_ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			state_q   <= TVS_ST_IDLE;
			result_q  <= '0;
			en_prev_q <= 4'h0;
			en_smp_q  <= 4'h0;
			extra_q   <= '0;
			cur_q     <= 2'h0;
		end else begin
			state_q   <= state_d;
			result_q  <= result_d;
			en_prev_q <= chan_enable;
			en_smp_q  <= en_smp_d;
			extra_q   <= extra_d;
			cur_q     <= cur_d;
		end
	end

	assign result       = result_q;
	assign result_valid = (state_q == TVS_ST_VALID);

	// ==========================================================
	// Checking helpers
	logic [23:0] lat_cnt_q, gap_cnt_q, rnd_cnt_q;
	logic [8:0]  wid_cnt_q;
	logic        first_q, pd_q, new_rnd_q;
	logic [1:0]  prev_ch_q;
	logic [7:0]  rate_h_q;

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			lat_cnt_q <= '0;
			gap_cnt_q <= '0;
			rnd_cnt_q <= '0;
			wid_cnt_q <= '0;
			first_q   <= 1'b0;
			pd_q      <= 1'b0;
			new_rnd_q <= 1'b0;
			prev_ch_q <= 2'h0;
			rate_h_q  <= 8'h00;
		end else begin
			lat_cnt_q <= (round_start && state_q == TVS_ST_IDLE) ?
				24'h000000 : lat_cnt_q + 24'h000001;
			gap_cnt_q <= conv_done ? 24'h000000 : gap_cnt_q + 24'h000001;
			rnd_cnt_q <= round_start ? 24'h000000 : rnd_cnt_q + 24'h000001;
			wid_cnt_q <= result_valid ? wid_cnt_q + 9'h001 : 9'h000;
			if (round_start && state_q == TVS_ST_IDLE) begin
				first_q <= 1'b1;
				pd_q    <= sensor_power_down;
			end else if (conv_done) begin
				first_q <= 1'b0;
			end
			if (round_start) begin
				new_rnd_q <= 1'b1;
				rate_h_q  <= rate_param;
			end else if (conv_done) begin
				new_rnd_q <= 1'b0;
				prev_ch_q <= cur_q;
			end
		end
	end

	// ==========================================================
	// Assertions
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (sys_rst);

	property p_first_range;
		conv_done && first_q |-> (int'(lat_cnt_q) + 1 >= FIRST_MIN_CYC) &&
			(int'(lat_cnt_q) + 1 <= FIRST_MAX_CYC);
	endproperty
	a_first_range: assert property (p_first_range)
		else $error("first conversion outside latency window");

	property p_first_fast;
		conv_done && first_q && !pd_q |-> int'(lat_cnt_q) + 1 == FIRST_MIN_CYC;
	endproperty
	a_first_fast: assert property (p_first_fast)
		else $error("first conversion not at least latency");

	property p_spacing;
		conv_done && !new_rnd_q |-> int'(gap_cnt_q) + 1 == SPACE_CYC;
	endproperty
	a_spacing: assert property (p_spacing)
		else $error("channel spacing wrong");

	property p_hold;
		!$rose(result_valid) |-> $stable(result);
	endproperty
	a_hold: assert property (p_hold)
		else $error("result changed outside valid rise");

	property p_width;
		$fell(result_valid) |-> (int'(wid_cnt_q) >= `TVS_VALID_MIN_CYC) &&
			(int'(wid_cnt_q) <= `TVS_VALID_MAX_CYC);
	endproperty
	a_width: assert property (p_width)
		else $error("valid width out of range");

	property p_cal;
		$fell(result_valid) |->
			int'(wid_cnt_q) == `TVS_VALID_MIN_CYC + int'(extra_q);
	endproperty
	a_cal: assert property (p_cal)
		else $error("valid width not set by calibration step");

	property p_round;
		round_start && state_q == TVS_ST_WAIT |->
			int'(rnd_cnt_q) + 1 == int'(rate_h_q) * RATE_UNIT_CYC;
	endproperty
	a_round: assert property (p_round)
		else $error("round period wrong");

	property p_stop;
		$fell(result_valid) && $past(en_smp_q) == 4'h0 |->
			state_q == TVS_ST_IDLE ##1 state_q == TVS_ST_IDLE;
	endproperty
	a_stop: assert property (p_stop)
		else $error("conversion continued after zero enables");

	property p_order;
		conv_done && !new_rnd_q |->
			cur_q > prev_ch_q && en_smp_q[cur_q];
	endproperty
	a_order: assert property (p_order)
		else $error("channel order wrong");

	property p_wait;
		state_q == TVS_ST_WAIT && !rate_zero |=> state_q == TVS_ST_WAIT;
	endproperty
	a_wait: assert property (p_wait)
		else $error("round started before rate timer ended");

	c_first: cover property (conv_done && first_q);
	c_wrap:  cover property (round_start && state_q == TVS_ST_WAIT);
	c_stop:  cover property ($fell(result_valid) ##1 state_q == TVS_ST_IDLE);
	c_skip:  cover property (conv_done && cur_q == 2'h3 &&
		prev_ch_q == 2'h0 && !new_rnd_q);
endmodule

// >>> verification/tvs_user.sv
// Partner model: user logic that feeds raw values and watches results.
// Assumes the sequencer's result port on the same clk_sys domain.
`timescale 1ns/1ps
module tvs_user (
	// Clock and reset
	input  wire logic                 clk_sys,
	input  wire logic                 sys_rst,
	// Result from the sequencer
	input  wire tvs_pkg::tvs_result_t result,
	input  wire logic                 result_valid,
	// Raw value for the sensor
	output tvs_pkg::tvs_sample_t      raw_sample
);
	import tvs_pkg::*;

	// ==========================================================
	// Result capture
	int unsigned cyc;
	int unsigned rise_cyc;
	int unsigned width;
	logic [5:0]  n_res;
	logic        v_q;
	logic        hold_bad;
	tvs_result_t r_q;
	tvs_result_t got;

	assign raw_sample = 16'h4A30 + {10'h000, n_res};

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			cyc <= 0;
			rise_cyc <= 0;
			width <= 0;
			n_res <= 6'h00;
			v_q <= 1'b0;
			hold_bad <= 1'b0;
			r_q <= '0;
			got <= '0;
		end else begin
			cyc <= cyc + 1;
			v_q <= result_valid;
			r_q <= result;
			if (result_valid && !v_q) begin
				rise_cyc <= cyc;
				got <= result;
				n_res <= n_res + 6'h01;
			end
			if (!result_valid && v_q)
				width <= cyc - rise_cyc;
			if (result !== r_q && !(result_valid && !v_q))
				hold_bad <= 1'b1;
		end
	end
endmodule

// >>> verification/tvs_seq_bench.sv
// Self-checking bench for the sensor sequencer, shortened counts.
// Assumes tvs_pkg, tvs_seq and tvs_user are compiled first.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin \
	err_count++; $display("unexpected %s exp %0h got %0h", nm, e, g); end end
module tvs_seq_bench;
	import tvs_pkg::*;
	localparam int F_MIN = 40;
	localparam int F_MAX = 60;
	localparam int SPACE = 500;
	localparam int UNIT  = 50;
	localparam int V_MIN = 325;
	localparam int V_MAX = 400;
	logic        clk_sys;
	logic        sys_rst;
	logic [3:0]  chan_enable;
	logic        sensor_power_down;
	logic [7:0]  rate_param;
	tvs_sample_t raw_sample;
	tvs_result_t result;
	logic        result_valid;
	int          err_count;
	int          num_checks;
	int unsigned t0;

	tvs_seq #(.FIRST_MIN_CYC(F_MIN), .FIRST_MAX_CYC(F_MAX),
		.SPACE_CYC(SPACE), .RATE_UNIT_CYC(UNIT)) DUT (
		.clk_sys(clk_sys), .sys_rst(sys_rst), .chan_enable(chan_enable),
		.sensor_power_down(sensor_power_down), .rate_param(rate_param),
		.raw_sample(raw_sample), .result(result),
		.result_valid(result_valid));
	tvs_user U (.clk_sys(clk_sys), .sys_rst(sys_rst), .result(result),
		.result_valid(result_valid), .raw_sample(raw_sample));

	initial begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end

	// ==========================================================
	// Shared tasks
	task automatic step(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic start(input logic [3:0] en, input logic pd,
		input logic [7:0] rate);
		sensor_power_down = pd;
		rate_param = rate;
		chan_enable = en;
		t0 = U.cyc;
	endtask

	task automatic wait_res(input int lim);
		logic [5:0] k;
		k = U.n_res;
		while (U.n_res === k && lim > 0) begin
			step(1);
			lim--;
		end
		`CHK("result arrival", 1'b1, lim > 0)
	endtask

	// New enables are driven early in the pulse, before the sample
	task automatic chk_res(input logic [1:0] ch, input int unsigned dt,
		input logic [3:0] en);
		chan_enable = en;
		`CHK("channel", ch, U.got.chan)
		`CHK("data", 16'h4A30 + U.n_res - 1, U.got.data)
		`CHK("spacing", dt, U.rise_cyc - t0)
		t0 = U.rise_cyc;
		while (result_valid === 1'b1)
			step(1);
		step(1);
		`CHK("width", V_MIN + ((48 + U.n_res - 1) % 64), U.width)
		`CHK("width range", 1'b1, U.width >= V_MIN && U.width <= V_MAX)
	endtask

	task automatic wait_none(input int n);
		logic [5:0] k;
		k = U.n_res;
		step(n);
		`CHK("results after stop", k, U.n_res)
	endtask

	// ==========================================================
	// Scenarios
	task automatic t_round();
		start(4'h9, 1'b0, 8'h1E);
		wait_res(F_MIN + 10);
		chk_res(2'h0, F_MIN + 1, 4'h9);
		wait_res(SPACE);
		chk_res(2'h3, SPACE, 4'h9);
		wait_res(rate_param * UNIT);
		chk_res(2'h0, rate_param * UNIT - F_MIN, 4'h0);
		wait_none(4000);
		$display("test round done");
	endtask

	task automatic t_pd();
		start(4'h4, 1'b1, 8'h0F);
		wait_res(F_MAX + 10);
		chk_res(2'h2, F_MAX + 1, 4'h4);
		wait_res(rate_param * UNIT + SPACE);
		chk_res(2'h2, rate_param * UNIT + SPACE - F_MAX, 4'h0);
		wait_none(4000);
		$display("test power down done");
	endtask

	task automatic t_order();
		start(4'hF, 1'b0, 8'h3C);
		wait_res(F_MIN + 10);
		chk_res(2'h0, F_MIN + 1, 4'hF);
		wait_res(SPACE);
		chk_res(2'h1, SPACE, 4'h5);
		wait_res(SPACE);
		chk_res(2'h2, SPACE, 4'h5);
		wait_res(rate_param * UNIT);
		chk_res(2'h0, rate_param * UNIT - F_MIN - SPACE, 4'h0);
		wait_none(4000);
		`CHK("result held", 1'b0, U.hold_bad)
		$display("test order done");
	endtask

	task automatic t_reset();
		start(4'h2, 1'b0, 8'h1E);
		step(20);
		sys_rst = 1'b1;
		step(2);
		`CHK("valid in reset", 1'b0, result_valid)
		`CHK("result in reset", 18'h00000, result)
		sys_rst = 1'b0;
		t0 = U.cyc;
		wait_res(F_MIN + 10);
		chk_res(2'h1, F_MIN + 1, 4'h0);
		wait_none(4000);
		$display("test reset done");
	endtask

	// ==========================================================
	// Main sequence and watchdog
	initial begin
		err_count = 0;
		num_checks = 0;
		t0 = 0;
		sys_rst = 1'b1;
		chan_enable = 4'h0;
		sensor_power_down = 1'b0;
		rate_param = 8'h1E;
		step(5);
		sys_rst = 1'b0;
		step(2);
		t_round();
		t_pd();
		t_order();
		t_reset();
		end_of_test();
	end

	initial begin
		repeat (40000) @(posedge clk_sys);
		err_count++;
		end_of_test();
	end
endmodule
